// ===== design/bitr_pkg.sv
package bitr_pkg;

  // ------------------------------------------------------------
  // Error code layout
  // ------------------------------------------------------------
  localparam int unsigned ERR_W        = 10;
  localparam logic [9:0]  ERR_PASS     = 10'h000;
  localparam int unsigned BIT_PROG_MEM = 0;
  localparam int unsigned BIT_WORK_MEM = 1;
  localparam int unsigned BIT_STORAGE  = 2;
  localparam int unsigned BIT_ISOBUF   = 3;
  localparam int unsigned BIT_REF      = 4;
  localparam int unsigned BIT_LOOPBACK = 5;
  localparam int unsigned BIT_MAX_OUT  = 6;
  localparam int unsigned BIT_MIN_OUT  = 7;
  localparam int unsigned BIT_QTR_OUT  = 8;
  localparam int unsigned BIT_QTR_RB   = 9;
  localparam int unsigned NUM_SUB      = 10;
  localparam int unsigned NUM_CONF     = 5;
  localparam logic [9:0]  CONF_MASK    = 10'h01f;
  localparam logic [9:0]  EXT_MASK     = 10'h3ff;

  // ------------------------------------------------------------
  // Address switch bank
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 5;
  localparam logic [4:0]  ADDR_ALL_ON  = 5'h1f;

  // ------------------------------------------------------------
  // Beep counts per failing subtest
  // ------------------------------------------------------------
  localparam logic [2:0]  BEEPS_MEM      = 3'h1;
  localparam logic [2:0]  BEEPS_STORAGE  = 3'h2;
  localparam logic [2:0]  BEEPS_ISOBUF   = 3'h3;
  localparam logic [2:0]  BEEPS_REF      = 3'h6;
  localparam logic [2:0]  BEEPS_LOOPBACK = 3'h5;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned BEEP_ON_MS   = 200;
  localparam int unsigned BEEP_GAP_MS  = 200;
  localparam int unsigned BEEP_PAUSE_MS = 1000;
  localparam int unsigned TOGGLE_MS    = 500;
  localparam int unsigned BEEP_ON_CYC  = CLK_HZ / 1000 * BEEP_ON_MS;
  localparam int unsigned BEEP_GAP_CYC = CLK_HZ / 1000 * BEEP_GAP_MS;
  localparam int unsigned PAUSE_CYC    = CLK_HZ / 1000 * BEEP_PAUSE_MS;
  localparam int unsigned TOGGLE_CYC   = CLK_HZ / 1000 * TOGGLE_MS;
  localparam int unsigned SUB_TMO_CYC  = 1024;
  localparam int unsigned TMR_W        = 32;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BITR_IDLE   = 3'b000,
    BITR_START  = 3'b001,
    BITR_WAIT   = 3'b010,
    BITR_NEXT   = 3'b011,
    BITR_BEEP   = 3'b100,
    BITR_GAP    = 3'b101,
    BITR_PAUSE  = 3'b110,
    BITR_BYPASS = 3'b111
  } bitr_state_e;

  typedef enum logic [1:0] {
    BITR_KIND_POWER = 2'b00,
    BITR_KIND_CONF  = 2'b01,
    BITR_KIND_EXT   = 2'b10,
    BITR_KIND_PER   = 2'b11
  } bitr_kind_e;

endpackage

// ===== design/bitr_top.sv
`timescale 1ns/1ps

// Overview of operation
// - Query returns zero on pass, else 1..1023
// - Every subtest runs even after a failure, except at power-up
// - Each failing subtest sets its own bit
// - Confidence test covers bits zero to four
// - Storage failure bit 2 sticks until calibration
// - Bits 5 to 9 only from extended test
// - Extended test checks one-volt limit, current mode
// - Extended test checks readback in both scales
// - Confidence test leaves output setting unchanged
// - Self-test at power-up, periodically, on command; queue, beep
// - Power-up beep counts per failing subtest
// - Power-up failure beeps, then repeats subtest until it passes
// - All switches on: skip test, toggle beeper
module bitr_top (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // Address switch bank pins
  input  wire logic [bitr_pkg::ADDR_W-1:0] address_switch_bank,
  // Test requests from command parser
  input  wire logic                        conf_test_req,
  input  wire logic                        instrument_test_query,
  input  wire logic                        periodic_test_req,
  input  wire logic                        calibration_stored,
  // Subtest engine handshake
  output logic [bitr_pkg::NUM_SUB-1:0]     sub_start,
  input  wire logic                        sub_done,
  input  wire logic                        sub_fail,
  // Extended test analog controls, output hold for other tests
  output logic                             ext_current_mode,
  output logic                             ext_limit_1v,
  output logic                             ext_high_scale,
  output logic                             output_hold,
  // Results
  output logic [bitr_pkg::ERR_W-1:0]       result_code,
  output logic                             result_valid,
  output logic                             error_push,
  output logic [bitr_pkg::ERR_W-1:0]       error_push_code,
  output logic                             busy,
  output logic                             beeper
);
  import bitr_pkg::*;

  // ------------------------------------------------------------
  // Switch synchroniser
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] sw_meta_reg;   // First stage
  logic [ADDR_W-1:0] sw_sync_reg;   // Second stage

  // Two flops before any logic reads the switches; no reset, so the
  // strap check right after release sees switches settled during reset
  always_ff @(posedge ref_clk) begin
    sw_meta_reg <= address_switch_bank;
    sw_sync_reg <= sw_meta_reg;
  end

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  bitr_state_e       state_reg,    state_next;     // Main state
  bitr_kind_e        kind_reg,     kind_next;      // Running test kind
  logic [3:0]        idx_reg,      idx_next;       // Subtest index
  logic [9:0]        code_reg,     code_next;      // Accumulated code
  logic [9:0]        res_reg,      res_next;       // Returned result
  logic              rv_reg,       rv_next;        // Result strobe
  logic              push_reg,     push_next;      // Queue strobe
  logic [9:0]        pcode_reg,    pcode_next;     // Queued code
  logic              stor_bad_reg, stor_bad_next;  // Sticky storage fault
  logic [TMR_W-1:0]  tmr_reg,      tmr_next;       // Beep/timeout timer
  logic [2:0]        beeps_reg,    beeps_next;     // Beeps left in group
  logic [9:0]        stor_code;                    // Sticky fault at its code bit
  logic              beep_reg,     beep_next;      // Beeper level
  logic              pwr_done_reg, pwr_done_next;  // Power-up test passed or bypass ended
  logic              strap_reg,    strap_next;     // Switch strap seen
  logic [9:0]        start_reg,    start_next;     // Subtest start pulses
  logic [3:0]        last_idx;                     // Last index for kind

  // Beep count lookup for a power-up subtest
  function automatic logic [2:0] beeps_for(input logic [3:0] i);
    unique case (i)
      4'h0, 4'h1: beeps_for = BEEPS_MEM;
      4'h2:       beeps_for = BEEPS_STORAGE;
      4'h3:       beeps_for = BEEPS_ISOBUF;
      4'h4:       beeps_for = BEEPS_REF;
      default:    beeps_for = BEEPS_LOOPBACK;
    endcase
  endfunction

  // Conf and power-up cover bits 0..4, extended covers 0..9
  assign last_idx = (kind_reg == BITR_KIND_EXT) ? 4'(NUM_SUB - 1)
                    : 4'(NUM_CONF - 1);

  // Sticky storage fault placed at its own code bit
  assign stor_code = {9'h000, stor_bad_reg} << BIT_STORAGE;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    kind_next     = kind_reg;
    idx_next      = idx_reg;
    code_next     = code_reg;
    res_next      = res_reg;
    rv_next       = 1'b0;
    push_next     = 1'b0;
    pcode_next    = pcode_reg;
    stor_bad_next = stor_bad_reg;
    tmr_next      = tmr_reg;
    beeps_next    = beeps_reg;
    beep_next     = beep_reg;
    pwr_done_next = pwr_done_reg;
    strap_next    = 1'b1;
    start_next    = '0;
    // Storage fault clears only after stored calibration
    if (calibration_stored) begin
      stor_bad_next = 1'b0;
    end
    unique case (state_reg)
      BITR_IDLE: begin
        if (!strap_reg) begin
          // First cycle after release: decide bypass or power-up
          if (sw_sync_reg == ADDR_ALL_ON) begin
            state_next = BITR_BYPASS;
            tmr_next   = '0;
          end else begin
            kind_next  = BITR_KIND_POWER;
            idx_next   = 4'h0;
            code_next  = '0;
            state_next = BITR_START;
          end
        end else if (instrument_test_query) begin
          kind_next  = BITR_KIND_EXT;
          idx_next   = 4'h0;
          code_next  = '0;
          state_next = BITR_START;
        end else if (conf_test_req || periodic_test_req) begin
          kind_next  = conf_test_req ? BITR_KIND_CONF : BITR_KIND_PER;
          idx_next   = 4'h0;
          code_next  = '0;
          state_next = BITR_START;
        end
      end
      BITR_START: begin
        // Launch the current subtest
        start_next[idx_reg] = 1'b1;
        tmr_next            = '0;
        state_next          = BITR_WAIT;
      end
      BITR_WAIT: begin
        tmr_next = tmr_reg + 1'b1;
        if (sub_done || tmr_reg == TMR_W'(SUB_TMO_CYC)) begin
          // Timeout counts as failure
          if (sub_fail || !sub_done) begin
            code_next[idx_reg] = 1'b1;
            if (idx_reg == 4'(BIT_STORAGE)) begin
              stor_bad_next = 1'b1;
            end
          end
          if (kind_reg == BITR_KIND_POWER && (sub_fail || !sub_done)) begin
            // Power-up failure: beep group then rerun same subtest
            beeps_next = beeps_for(idx_reg);
            tmr_next   = '0;
            beep_next  = 1'b1;
            state_next = BITR_BEEP;
          end else begin
            state_next = BITR_NEXT;
          end
        end
      end
      BITR_NEXT: begin
        if (idx_reg == last_idx) begin
          // Whole pass done; storage fault stays sticky
          res_next = code_reg | stor_code;
          if (kind_reg == BITR_KIND_CONF || kind_reg == BITR_KIND_EXT) begin
            rv_next = 1'b1;
          end
          if (code_reg != '0 || stor_bad_reg) begin
            push_next  = 1'b1;
            pcode_next = code_reg | stor_code;
          end
          if (kind_reg == BITR_KIND_POWER) begin
            pwr_done_next = 1'b1;
          end
          state_next = BITR_IDLE;
        end else begin
          idx_next   = idx_reg + 1'b1;
          state_next = BITR_START;
        end
      end
      BITR_BEEP: begin
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg == TMR_W'(BEEP_ON_CYC - 1)) begin
          beep_next  = 1'b0;
          tmr_next   = '0;
          beeps_next = beeps_reg - 1'b1;
          state_next = (beeps_reg == 3'h1) ? BITR_PAUSE : BITR_GAP;
        end
      end
      BITR_GAP: begin
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg == TMR_W'(BEEP_GAP_CYC - 1)) begin
          beep_next  = 1'b1;
          tmr_next   = '0;
          state_next = BITR_BEEP;
        end
      end
      BITR_PAUSE: begin
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg == TMR_W'(PAUSE_CYC - 1)) begin
          push_next  = 1'b1;
          pcode_next = code_reg;
          state_next = BITR_START;
        end
      end
      BITR_BYPASS: begin
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg == TMR_W'(TOGGLE_CYC - 1)) begin
          beep_next = ~beep_reg;
          tmr_next  = '0;
        end
        if (sw_sync_reg != ADDR_ALL_ON) begin
          beep_next     = 1'b0;
          pwr_done_next = 1'b1;
          state_next    = BITR_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg    <= BITR_IDLE;
      kind_reg     <= BITR_KIND_POWER;
      idx_reg      <= 4'h0;
      code_reg     <= ERR_PASS;
      res_reg      <= ERR_PASS;
      rv_reg       <= 1'b0;
      push_reg     <= 1'b0;
      pcode_reg    <= ERR_PASS;
      stor_bad_reg <= 1'b0;
      tmr_reg      <= '0;
      beeps_reg    <= 3'h0;
      beep_reg     <= 1'b0;
      pwr_done_reg <= 1'b0;
      strap_reg    <= 1'b0;
      start_reg    <= '0;
    end else begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      idx_reg      <= idx_next;
      code_reg     <= code_next;
      res_reg      <= res_next;
      rv_reg       <= rv_next;
      push_reg     <= push_next;
      pcode_reg    <= pcode_next;
      stor_bad_reg <= stor_bad_next;
      tmr_reg      <= tmr_next;
      beeps_reg    <= beeps_next;
      beep_reg     <= beep_next;
      pwr_done_reg <= pwr_done_next;
      strap_reg    <= strap_next;
      start_reg    <= start_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sub_start        = start_reg;
  assign result_code      = res_reg;
  assign result_valid     = rv_reg;
  assign error_push       = push_reg;
  assign error_push_code  = pcode_reg;
  assign busy             = (state_reg != BITR_IDLE) || !pwr_done_reg;
  assign beeper           = beep_reg;
  // Limit step runs in current mode with one-volt limit
  assign ext_current_mode = (kind_reg == BITR_KIND_EXT) && (idx_reg == 4'(BIT_LOOPBACK))
                            && (state_reg == BITR_WAIT);
  assign ext_limit_1v     = ext_current_mode;
  // Readback step: high scale for max output, low for quarter scale
  assign ext_high_scale   = (kind_reg == BITR_KIND_EXT) && (idx_reg != 4'(BIT_QTR_RB));
  // Output setting frozen while any test other than the extended test runs
  assign output_hold      = (state_reg != BITR_IDLE) && (kind_reg != BITR_KIND_EXT);

endmodule

// ===== test/bitr_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reporter port checker
// ----------------------------------------
module bitr_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Subtest handshake
  input wire logic [9:0] sub_start,
  input wire logic       sub_done,
  // Controls and results
  input wire logic       ext_current_mode,
  input wire logic       ext_limit_1v,
  input wire logic       ext_high_scale,
  input wire logic       output_hold,
  input wire logic [9:0] result_code,
  input wire logic       result_valid,
  input wire logic       error_push,
  input wire logic [9:0] error_push_code,
  input wire logic       busy,
  input wire logic       beeper
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [9:0] cur_reg;  // Last started subtest
  logic [9:0] cur_next; // Its next value
  // Track the subtest in flight
  always_comb begin
    cur_next = (sub_start != 10'h000) ? sub_start : cur_reg;
  end
  always_ff @(posedge ref_clk) begin
    cur_reg <= reset ? 10'h000 : cur_next;
  end
  AST_ONEHOT: assert property ($onehot0(sub_start)) else $error("start not one-hot");
  AST_STEP: assert property (sub_done && ext_high_scale && (cur_reg[8:0] != 9'h000)
    |-> ##[1:4] (sub_start == {cur_reg[8:0], 1'b0})) else $error("next subtest not started");
  AST_PUSH: assert property (result_valid && (result_code != 10'h000)
    |-> error_push && (error_push_code == result_code)) else $error("failed pass not queued");
  AST_PUSH_NZ: assert property (error_push |-> error_push_code != 10'h000) else $error("zero queued");
  AST_LIMIT: assert property ($rose(ext_current_mode) |-> sub_start[5] && ext_limit_1v)
    else $error("limit check misplaced");
  AST_LOWSCALE: assert property (sub_start[9] |-> !ext_high_scale ##1 !ext_high_scale)
    else $error("low scale not used");
  AST_HOLD: assert property ((sub_start[4:0] != 5'h00) && !ext_high_scale
    |-> output_hold && !ext_current_mode) else $error("output not held");
  AST_EXT_ONLY: assert property ((sub_start[9:5] != 5'h00) |-> ext_high_scale || sub_start[9])
    else $error("extended subtest outside extended test");
  AST_BUSY: assert property ((sub_start != 10'h000) |-> busy ##1 busy) else $error("not busy");
  // Beeper only sounds while the power-up test or bypass holds the card
  AST_BEEP_BUSY: assert property (beeper |-> busy) else $error("beeper outside self-test");
  CV_FAIL: cover property (result_valid && result_code != 10'h000);
  CV_EXT: cover property (sub_start[9]);
  CV_PUSH: cover property (error_push && !result_valid);
  CV_BEEP: cover property (beeper);
endmodule

bind bitr_top bitr_checker u_bitr_checker (
  .ref_clk(ref_clk), .reset(reset), .sub_start(sub_start), .sub_done(sub_done),
  .ext_current_mode(ext_current_mode), .ext_limit_1v(ext_limit_1v), .ext_high_scale(ext_high_scale),
  .output_hold(output_hold), .result_code(result_code), .result_valid(result_valid),
  .error_push(error_push), .error_push_code(error_push_code), .busy(busy), .beeper(beeper)
);

// ===== test/bitr_sub_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Subtest engine model
// ----------------------------------------
module bitr_sub_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Plan from the bench
  input  wire logic [9:0] fail_mask,
  input  wire logic [9:0] hang_mask,
  input  wire logic [3:0] delay,
  // Handshake with reporter
  input  wire logic [9:0] sub_start,
  output logic            sub_done,
  output logic            sub_fail
);
  logic [9:0] idx_reg; // Subtest in flight
  logic [4:0] cnt_reg; // Cycles left, zero idle
  // Answer each start after a delay, or never if hung
  always @(posedge ref_clk) begin
    sub_done <= 1'b0;
    sub_fail <= ~sub_fail;
    if (reset) begin
      cnt_reg  <= 5'h00;
      sub_fail <= 1'b0;
    end else if (sub_start != 10'h000) begin
      idx_reg <= sub_start;
      cnt_reg <= ((sub_start & hang_mask) != 10'h000) ? 5'h00 : {1'b0, delay} + 5'h01;
    end else if (cnt_reg == 5'h01) begin
      sub_done <= 1'b1;
      sub_fail <= |(idx_reg & fail_mask);
      cnt_reg  <= 5'h00;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reporter testbench
// ----------------------------------------
module tb;
  import bitr_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1;
  logic [4:0]  address_switch_bank = 5'h03; // Valid address, test runs
  logic        conf_test_req = 1'b0, instrument_test_query = 1'b0;
  logic        periodic_test_req = 1'b0, calibration_stored = 1'b0;
  logic [9:0]  fail_mask = 10'h000, hang_mask = 10'h000;
  logic [3:0]  delay = 4'h0;
  logic [9:0]  sub_start, result_code, error_push_code;
  logic        sub_done, sub_fail, ext_current_mode, ext_limit_1v, ext_high_scale;
  logic        output_hold, result_valid, error_push, busy, beeper;
  logic [31:0] seed = 32'hfc42;  // Random state
  logic        sticky = 1'b0;    // Expected stored fault
  int          err_count = 0, compares = 0, i;
  int          starts = 0, s0;   // Subtest launches seen, snapshot
  always #10 ref_clk = ~ref_clk;
  // Count subtest launches to prove a skipped power-up test
  always @(posedge ref_clk) starts <= starts + int'(sub_start != 10'h000);
  bitr_top u_bitr_top (.ref_clk(ref_clk), .reset(reset), .address_switch_bank(address_switch_bank),
    .conf_test_req(conf_test_req), .instrument_test_query(instrument_test_query),
    .periodic_test_req(periodic_test_req), .calibration_stored(calibration_stored),
    .sub_start(sub_start), .sub_done(sub_done), .sub_fail(sub_fail), .ext_current_mode(ext_current_mode),
    .ext_limit_1v(ext_limit_1v), .ext_high_scale(ext_high_scale), .output_hold(output_hold),
    .result_code(result_code), .result_valid(result_valid), .error_push(error_push),
    .error_push_code(error_push_code), .busy(busy), .beeper(beeper));
  bitr_sub_model u_bitr_sub_model (.ref_clk(ref_clk), .reset(reset), .fail_mask(fail_mask),
    .hang_mask(hang_mask), .delay(delay), .sub_start(sub_start), .sub_done(sub_done), .sub_fail(sub_fail));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Failed subtests masked to the test kind, plus stored fault
  function automatic logic [9:0] exp_code(input logic [9:0] m, input logic ext, input logic st);
    return (m & (ext ? EXT_MASK : CONF_MASK)) | {7'h00, st, 2'h0};
  endfunction
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  // One-bit flag compare
  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One test pass: 0 confidence, 1 extended, 2 periodic
  task automatic run(input int kind, input logic [9:0] fm, input logic [9:0] hm);
    int n;
    logic [9:0] exp;
    seed = xs(seed);
    @(posedge ref_clk);
    fail_mask <= fm;
    hang_mask <= hm;
    delay <= seed[3:0];
    conf_test_req <= (kind == 0);
    instrument_test_query <= (kind == 1);
    periodic_test_req <= (kind == 2);
    @(posedge ref_clk);
    {conf_test_req, instrument_test_query, periodic_test_req} <= 3'b000;
    @(posedge ref_clk);
    conf_test_req <= 1'b1; // Refused while busy
    @(posedge ref_clk);
    conf_test_req <= 1'b0;
    exp = exp_code(fm | hm, kind == 1, sticky);
    sticky = exp[2];
    n = 0;
    #1;
    while (((kind == 2) ? error_push : result_valid) !== 1'b1 && n < 15000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check_bit("result_seen", 1'h1, n < 15000);
    check("result_code", exp, (kind == 2) ? error_push_code : result_code);
    check_bit("push", exp != 10'h000, error_push);
    repeat (4) @(posedge ref_clk);
    #1;
    check_bit("busy", 1'h0, busy);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (400) @(posedge ref_clk);
    #1;
    check_bit("powerup_busy", 1'h0, busy);
    run(0, 10'h000, 10'h000);
    run(0, 10'h01b, 10'h000);
    run(0, 10'h004, 10'h000);
    run(0, 10'h000, 10'h000);
    @(posedge ref_clk);
    calibration_stored <= 1'b1;
    @(posedge ref_clk);
    calibration_stored <= 1'b0;
    sticky = 1'b0;
    run(0, 10'h3e0, 10'h002);
    run(1, 10'h3e8, 10'h000);
    run(2, 10'h008, 10'h000);
    run(1, 10'h000, 10'h200);
    for (i = 0; i < 12; i++) begin
      seed = xs(seed);
      run(seed[0] ? 1 : 0, seed[17:8], 10'h000);
    end
    // Mid-run reset with every switch on: power-up test skipped
    @(posedge ref_clk);
    reset <= 1'b1;
    address_switch_bank <= 5'h1f;
    repeat (8) @(posedge ref_clk);
    #1;
    check("reset_code", ERR_PASS, result_code);
    check_bit("reset_busy", 1'h1, busy);
    s0 = starts;
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1;
    check_bit("bypass_busy", 1'h1, busy);
    check_bit("bypass_beeper", 1'h0, beeper);
    check_bit("bypass_start", 1'h0, starts != s0);
    // Valid address ends the bypass without any subtest
    @(posedge ref_clk);
    address_switch_bank <= 5'h03;
    repeat (5) @(posedge ref_clk);
    #1;
    check_bit("bypass_exit", 1'h0, busy);
    check_bit("bypass_skip", 1'h0, starts != s0);
    // Mid-run reset with a failing memory subtest at power-up
    @(posedge ref_clk);
    reset <= 1'b1;
    fail_mask <= 10'h001;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (60) @(posedge ref_clk);
    #1;
    check_bit("powerup_beeper", 1'h1, beeper);
    check_bit("powerup_stuck", 1'h1, busy);
    check_bit("powerup_queue", 1'h0, error_push);
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    #(90000 * 20);
    $display("MISMATCH watchdog expected done seen running");
    err_count++;
    complete_run;
  end
endmodule
